/* tmrps_pkg.sv */
// Constants for the 8-bit tick timer with shared prescaler
// Contract
// - Clock source zero: count once per instruction cycle before prescaling.
// - A count register write blocks counting for two instruction cycles.
// - Clock source one: count external pin edges; edge select zero rising.
// - Count wrapping from FFh to 00h sets the overflow flag.
// - Overflow request masked while its enable bit is zero.
// - Overflow flag stays set until software writes zero; software clears before re-enable.
// - Timer halted during sleep, so overflow cannot wake the processor.
// - External clock synchronised by sampling prescaler output in phases two and four.
// - Prescaler not assigned to timer: external clock passes through undivided.
// - Pull-up disable one turns off all port A pull-ups; zero uses per-pin settings.
// - External interrupt edge select: one rising, zero falling pin edge.
// - Prescaler assign one connects prescaler to watchdog; zero to timer.
// - Rate codes give timer 1:2 to 1:256, watchdog 1:1 to 1:128.
// - Prescaler is an 8-bit counter software cannot read or write.
// - With prescaler on timer, every count register write clears the prescaler.
// - With prescaler on watchdog, a watchdog clear also clears the prescaler.
// - Interrupt sources recognised only while global interrupt enable is set.
package tmrps_pkg;
   // Register byte addresses (printed offsets are indices, address is four times)
   localparam logic [7:0]  IDX_TICK_COUNT   = 8'h01;
   localparam logic [7:0]  IDX_IRQ_CONTROL  = 8'h0B;
   localparam logic [7:0]  IDX_OPTION       = 8'h81;
   localparam logic [11:0] ADDR_TICK_COUNT  = {2'h0, IDX_TICK_COUNT, 2'h0};
   localparam logic [11:0] ADDR_IRQ_CONTROL = {2'h0, IDX_IRQ_CONTROL, 2'h0};
   localparam logic [11:0] ADDR_OPTION      = {2'h0, IDX_OPTION, 2'h0};
   localparam logic [11:0] ADDR_CONTROL     = 12'h400;
   // Reset values
   localparam logic [7:0]  IRQ_CONTROL_RST  = 8'h00;
   localparam logic [7:0]  OPTION_RST       = 8'hFF;
   localparam logic [7:0]  TICK_COUNT_RST   = 8'h00;
   // Option fields
   localparam int OPT_PULLUP_DIS  = 7;
   localparam int OPT_EXT_EDGE    = 6;
   localparam int OPT_CLK_SRC     = 5;
   localparam int OPT_TICK_EDGE   = 4;
   localparam int OPT_PS_ASSIGN   = 3;
   // Interrupt control fields
   localparam int IC_GLOBAL_EN    = 7;
   localparam int IC_OVF_EN       = 5;
   localparam int IC_EXT_EN       = 4;
   localparam int IC_OVF_FLAG     = 2;
   localparam int IC_EXT_FLAG     = 1;
   // Control register fields (sleep, watchdog clear)
   localparam int CTL_SLEEP       = 0;
   localparam int CTL_WDT_CLEAR   = 1;
   // Timing
   localparam int PHASES_PER_CYCLE   = 4;
   localparam int WRITE_INHIBIT_CYC  = 2;
   localparam logic [1:0] PHASE_TWO  = 2'h1;
   localparam logic [1:0] PHASE_FOUR = 2'h3;
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

/* tmrps_top.sv */
// Tick timer, shared prescaler and option/interrupt control with AXI4-Lite access
`timescale 1ns/1ps
module tmrps_top (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Pins
   input  wire logic        tick_ext_clock_pin,
   input  wire logic        ext_irq_pin,
   // Port A pull-up control
   input  wire logic [5:0]  port_a_pullup_individual,
   output logic [5:0]       port_a_pullup_enable,
   // Watchdog hookup
   output logic             watchdog_tick,
   output logic             watchdog_clear,
   // Interrupt request to the core
   output logic             irq_request
);
   logic [7:0] tick_count_q;
   logic [7:0] irq_control_q;
   logic [7:0] option_q;
   logic       sleep_q;
   logic [7:0] prescaler_q;
   logic [1:0] phase_q;
   logic [1:0] inhibit_q;
   logic [1:0] tck_sync_q;
   logic [1:0] eirq_sync_q;
   logic       eirq_prev_q;
   logic       ps_out_prev_q;
   logic       ps_samp_q;
   logic       ps_samp_prev_q;
   logic       ps_samp_new_q;
   logic       edge_prev_q;
   logic       aw_held_q;
   logic       w_held_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;

   logic       wr_fire;
   logic       wr_count;
   logic       wr_irq;
   logic       wr_option;
   logic       wr_control;
   logic       ps_to_wdt;
   logic       cycle_end;
   logic       src_in;
   logic       src_edge;
   logic       ps_tap;
   logic       wdt_tap;
   logic       ps_out;
   logic       tick_pulse;
   logic       eirq_edge;
   logic [7:0] wr_byte;

   // Instruction cycle closes at phase four; none closes in sleep, where the phase is frozen
   assign cycle_end = (phase_q == tmrps_pkg::PHASE_FOUR) && !sleep_q;
   assign ps_to_wdt = option_q[tmrps_pkg::OPT_PS_ASSIGN];

   // Write channel: address and data may arrive in either order
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
   assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_byte       = wstrb_q[0] ? wdata_q[7:0] : 8'h00;
   assign wr_count      = wr_fire && wstrb_q[0] && awaddr_q == tmrps_pkg::ADDR_TICK_COUNT;
   assign wr_irq        = wr_fire && wstrb_q[0] && awaddr_q == tmrps_pkg::ADDR_IRQ_CONTROL;
   assign wr_option     = wr_fire && wstrb_q[0] && awaddr_q == tmrps_pkg::ADDR_OPTION;
   assign wr_control    = wr_fire && wstrb_q[0] && awaddr_q == tmrps_pkg::ADDR_CONTROL;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awaddr_q  <= 12'h000;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= tmrps_pkg::AXI_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         if (awaddr_q == tmrps_pkg::ADDR_TICK_COUNT || awaddr_q == tmrps_pkg::ADDR_IRQ_CONTROL
             || awaddr_q == tmrps_pkg::ADDR_OPTION || awaddr_q == tmrps_pkg::ADDR_CONTROL) begin
            s_axi_bresp <= tmrps_pkg::AXI_OKAY;
         end else begin
            s_axi_bresp <= tmrps_pkg::AXI_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel: one read at a time, answer one cycle after the address
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= tmrps_pkg::AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= tmrps_pkg::AXI_OKAY;
         // The prescaler value is never mapped, so software cannot see it
         unique case (s_axi_araddr)
            tmrps_pkg::ADDR_TICK_COUNT:  s_axi_rdata <= {24'h000000, tick_count_q};
            tmrps_pkg::ADDR_IRQ_CONTROL: s_axi_rdata <= {24'h000000, irq_control_q};
            tmrps_pkg::ADDR_OPTION:      s_axi_rdata <= {24'h000000, option_q};
            tmrps_pkg::ADDR_CONTROL:     s_axi_rdata <= {31'h0000_0000, sleep_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= tmrps_pkg::AXI_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Option and control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         option_q <= tmrps_pkg::OPTION_RST;
      end else if (wr_option) begin
         option_q <= wr_byte;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_q <= 1'b0;
      end else if (wr_control) begin
         sleep_q <= wr_byte[tmrps_pkg::CTL_SLEEP];
      end
   end

   assign watchdog_clear = wr_control && wr_byte[tmrps_pkg::CTL_WDT_CLEAR];

   // Phase counter, frozen in sleep so the whole timer stops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_q <= 2'h0;
      end else if (!sleep_q) begin
         phase_q <= phase_q + 2'h1;
      end
   end

   // Pin synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tck_sync_q  <= 2'h0;
         eirq_sync_q <= 2'h0;
      end else begin
         tck_sync_q  <= {tck_sync_q[0], tick_ext_clock_pin};
         eirq_sync_q <= {eirq_sync_q[0], ext_irq_pin};
      end
   end

   // Edge select inverts the pin so a rising edge of src_in is always the count edge
   assign src_in = option_q[tmrps_pkg::OPT_CLK_SRC]
                   ? (tck_sync_q[1] ^ option_q[tmrps_pkg::OPT_TICK_EDGE])
                   : cycle_end;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Reset-state source is the inverted idle-low pin, so start high to avoid a false edge
         edge_prev_q <= 1'b1;
      end else begin
         edge_prev_q <= src_in;
      end
   end

   assign src_edge = src_in && !edge_prev_q && !sleep_q;

   // Shared 8-bit prescaler; the watchdog uses it as a postscaler
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescaler_q <= 8'h00;
      end else if (!ps_to_wdt && wr_count) begin
         prescaler_q <= 8'h00;
      end else if (ps_to_wdt && watchdog_clear) begin
         prescaler_q <= 8'h00;
      end else if (ps_to_wdt ? cycle_end : src_edge) begin
         prescaler_q <= prescaler_q + 8'h01;
      end
   end

   // Timer taps bit rate (1:2 at 000), watchdog taps one below (1:1 at 000)
   assign ps_tap  = prescaler_q[option_q[2:0]];
   assign wdt_tap = prescaler_q[3'(option_q[2:0] - 3'h1)];
   assign ps_out  = ps_to_wdt ? src_in : ps_tap;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ps_out_prev_q <= 1'b0;
      end else begin
         ps_out_prev_q <= wdt_tap;
      end
   end

   assign watchdog_tick = ps_to_wdt &&
                          ((option_q[2:0] == 3'h0) ? cycle_end : (wdt_tap && !ps_out_prev_q));

   // Prescaler output sampled at phase two and phase four
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ps_samp_q      <= 1'b1;
         ps_samp_prev_q <= 1'b1;
      end else if (!sleep_q && (phase_q == tmrps_pkg::PHASE_TWO || cycle_end)) begin
         ps_samp_q      <= ps_out;
         ps_samp_prev_q <= ps_samp_q;
      end
   end

   // Marks the cycle after each sample, so a rise seen at either phase counts once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ps_samp_new_q <= 1'b0;
      end else begin
         ps_samp_new_q <= !sleep_q && (phase_q == tmrps_pkg::PHASE_TWO || cycle_end);
      end
   end

   // Internal mode without prescaler counts each cycle end directly
   assign tick_pulse = !sleep_q && inhibit_q == 2'h0 &&
      ((ps_to_wdt && !option_q[tmrps_pkg::OPT_CLK_SRC]) ? cycle_end
       : (ps_samp_new_q && ps_samp_q && !ps_samp_prev_q));

   // Write inhibit lasts through the next two instruction cycle ends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         inhibit_q <= 2'h0;
      end else if (wr_count) begin
         inhibit_q <= 2'(tmrps_pkg::WRITE_INHIBIT_CYC);
      end else if (cycle_end && inhibit_q != 2'h0) begin
         inhibit_q <= inhibit_q - 2'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_count_q <= tmrps_pkg::TICK_COUNT_RST;
      end else if (wr_count) begin
         tick_count_q <= wr_byte;
      end else if (tick_pulse) begin
         tick_count_q <= tick_count_q + 8'h01;
      end
   end

   // External interrupt edge detect on the synchronised pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eirq_prev_q <= 1'b0;
      end else begin
         eirq_prev_q <= eirq_sync_q[1];
      end
   end

   assign eirq_edge = option_q[tmrps_pkg::OPT_EXT_EDGE]
                      ? (eirq_sync_q[1] && !eirq_prev_q)
                      : (!eirq_sync_q[1] && eirq_prev_q);

   // Interrupt control: hardware set wins over a software clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_control_q <= tmrps_pkg::IRQ_CONTROL_RST;
      end else begin
         if (wr_irq) begin
            irq_control_q <= wr_byte;
         end
         if (tick_pulse && tick_count_q == 8'hFF) begin
            irq_control_q[tmrps_pkg::IC_OVF_FLAG] <= 1'b1;
         end
         if (eirq_edge) begin
            irq_control_q[tmrps_pkg::IC_EXT_FLAG] <= 1'b1;
         end
      end
   end

   assign irq_request = irq_control_q[tmrps_pkg::IC_GLOBAL_EN] &&
      ((irq_control_q[tmrps_pkg::IC_OVF_EN] && irq_control_q[tmrps_pkg::IC_OVF_FLAG])
       || (irq_control_q[tmrps_pkg::IC_EXT_EN] && irq_control_q[tmrps_pkg::IC_EXT_FLAG]));

   // Pull-ups: a global off overrides every pin
   assign port_a_pullup_enable = option_q[tmrps_pkg::OPT_PULLUP_DIS]
                                 ? 6'h00 : port_a_pullup_individual;
endmodule

/* tmrps_monitor.sv */
// Port checker for the tick timer with shared prescaler
`timescale 1ns/1ps
module tmrps_monitor (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register write channels
   input wire logic [11:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   // Pull-ups, watchdog and interrupt
   input wire logic [5:0]  port_a_pullup_individual,
   input wire logic [5:0]  port_a_pullup_enable,
   input wire logic        watchdog_tick,
   input wire logic        watchdog_clear,
   input wire logic        irq_request
);
   // Only writes whose two beats are taken on one edge are tracked
   wire logic       wr_take  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                               && s_axi_wstrb[0];
   wire logic       opt_take = wr_take && s_axi_awaddr == tmrps_pkg::ADDR_OPTION;
   wire logic       ic_take  = wr_take && s_axi_awaddr == tmrps_pkg::ADDR_IRQ_CONTROL;
   wire logic       ctl_take = wr_take && s_axi_awaddr == tmrps_pkg::ADDR_CONTROL;
   wire logic [7:0] wd       = s_axi_wdata[7:0];
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // A register changes one edge after the take, so ports show it two edges on
   sequence s_ovf_armed;
      ic_take && wd[7] && wd[5] && wd[2];
   endsequence
   sequence s_wdt_clear;
      ctl_take && wd[1];
   endsequence
   AST_PULLUP_OFF: assert property (
      opt_take && wd[7] |-> ##2 port_a_pullup_enable == 6'h00)
      else $error("pull-ups stay on after disable");
   AST_PULLUP_PASS: assert property (
      opt_take && !wd[7] |-> ##2 port_a_pullup_enable == port_a_pullup_individual)
      else $error("pull-ups do not follow per-pin settings");
   AST_GIE_MASK: assert property (
      ic_take && !wd[7] |-> ##2 !irq_request)
      else $error("request without global enable");
   AST_OVF_MASK: assert property (
      ic_take && !wd[5] && !wd[4] |-> ##2 !irq_request)
      else $error("request with all sources masked");
   AST_FLAG_IRQ: assert property (
      s_ovf_armed |-> ##2 irq_request)
      else $error("set overflow flag gives no request");
   AST_IRQ_HOLD: assert property (
      irq_request && !$past(ic_take) |=> irq_request)
      else $error("request dropped without software write");
   AST_WDT_CLR: assert property (
      s_wdt_clear |-> ##[1:2] watchdog_clear)
      else $error("watchdog clear not issued");
   AST_WDT_CLR_PULSE: assert property (
      watchdog_clear |=> !watchdog_clear)
      else $error("watchdog clear longer than one cycle");
   AST_WDT_TICK_OFF: assert property (
      opt_take && !wd[3] |-> ##2 !watchdog_tick [*3])
      else $error("watchdog ticks while prescaler is on the timer");
endmodule

bind tmrps_top tmrps_monitor u_mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
   .port_a_pullup_individual, .port_a_pullup_enable, .watchdog_tick, .watchdog_clear,
   .irq_request);

/* tmrps_clk_src.sv */
// External count clock source for the tick timer input pin
`timescale 1ns/1ps
module tmrps_clk_src (
   // Clock
   input wire logic aclk,
   // Count clock pin
   output logic     tick_ext_clock_pin
);
   initial tick_ext_clock_pin = 1'b0;
   // Idles low between bursts; a short level would be lost in synchronisation
   task automatic send(input int n, input int half);
      repeat (n) begin
         tick_ext_clock_pin <= 1'b1;
         repeat (half) @(posedge aclk);
         tick_ext_clock_pin <= 1'b0;
         repeat (half) @(posedge aclk);
      end
   endtask
endmodule

/* tb_top.sv */
// Register-level bench for the tick timer with shared prescaler
`timescale 1ns/1ps
module tb_top;
   localparam logic [11:0] A_CNT = tmrps_pkg::ADDR_TICK_COUNT;
   localparam logic [11:0] A_IC  = tmrps_pkg::ADDR_IRQ_CONTROL;
   localparam logic [11:0] A_OPT = tmrps_pkg::ADDR_OPTION;
   localparam logic [11:0] A_CTL = tmrps_pkg::ADDR_CONTROL;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, tick_ext_clock_pin, ext_irq_pin, watchdog_tick, watchdog_clear;
   logic        irq_request;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [5:0]  port_a_pullup_individual, port_a_pullup_enable;
   logic [7:0]  c0;
   int          fail_count, n_tests;
   int          wdt_ticks, w0;

   tmrps_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .tick_ext_clock_pin, .ext_irq_pin, .port_a_pullup_individual,
      .port_a_pullup_enable, .watchdog_tick, .watchdog_clear, .irq_request);
   tmrps_clk_src src (.aclk, .tick_ext_clock_pin);

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // Running count of watchdog increments handed out by the postscaler
   always @(posedge aclk) begin
      if (watchdog_tick === 1'b1) begin
         wdt_ticks <= wdt_ticks + 1;
      end
   end

   task automatic stop_test();
      if (fail_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tmo();
      fail_count++;
      $display("ERROR bus handshake expected response seen none");
      stop_test();
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while ((s_axi_awready && s_axi_wready) !== 1'b1 && n < 100);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 200);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 200) tmo();
   endtask

   task automatic rd(input logic [11:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 100);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 200);
      rd_data = s_axi_rdata;
      resp    = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 200) tmo();
   endtask

   // About four counts over the gap; read overhead widens the window by one
   task automatic rate_chk(input int gap);
      wr(A_CNT, 8'h00);
      repeat (16) @(posedge aclk);
      rd(A_CNT);
      c0 = rd_data[7:0];
      repeat (gap) @(posedge aclk);
      rd(A_CNT);
      chk("count rate", 32'h1, {31'h0, (rd_data[7:0] - c0) inside {[8'h03:8'h06]}});
   endtask

   task automatic ext_chk(input logic [7:0] opt, input int n, input logic [31:0] exp);
      wr(A_CTL, 8'h02);
      wr(A_OPT, opt);
      wr(A_CNT, 8'h00);
      // Let the two-cycle write inhibit run out before the first pin edge
      repeat (12) @(posedge aclk);
      src.send(n, 12);
      repeat (20) @(posedge aclk);
      rd(A_CNT);
      chk("external count", exp, rd_data);
   endtask

   task automatic pin_chk(input logic v, input logic [31:0] exp);
      ext_irq_pin <= v;
      repeat (10) @(posedge aclk);
      rd(A_IC);
      chk("edge flag", exp, rd_data);
   endtask

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_irq_pin} = '0;
      s_axi_wstrb = 4'h1;
      port_a_pullup_individual = 6'h2D;
      fail_count = 0;
      n_tests = 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_IC);
      chk("irq control reset", 32'h00, rd_data);
      rd(A_OPT);
      chk("option reset", 32'hFF, rd_data);
      rd(A_CNT);
      chk("count reset", 32'h00, rd_data);
      chk("pull-ups at reset", 32'h00, {26'h0, port_a_pullup_enable});
      rd(12'h010);
      chk("unmapped read", 32'h2, {rd_data[29:0], resp});
      wr(12'h010, 8'h55);
      chk("unmapped write", 32'h2, {30'h0, resp});
      wr(A_OPT, 8'h7F);
      chk("pull-ups per pin", 32'h2D, {26'h0, port_a_pullup_enable});
      for (int i = 0; i < 8; i++) begin
         wr(A_CTL, 8'h02);
         wr(A_OPT, 8'(i));
         rate_chk(32 << i);
      end
      wr(A_CTL, 8'h02);
      wr(A_CNT, 8'h00);
      wr(A_OPT, 8'h2F);
      wr(A_CTL, 8'h02);
      wr(A_OPT, 8'h08);
      wr(A_CNT, 8'h10);
      rd(A_CNT);
      chk("count after write", 32'h10, rd_data);
      rate_chk(16);
      wr(A_IC, 8'h00);
      wr(A_CNT, 8'hFE);
      repeat (40) @(posedge aclk);
      rd(A_IC);
      chk("overflow flag", 32'h04, rd_data);
      chk("request masked", 32'h0, {31'h0, irq_request});
      wr(A_IC, 8'h24);
      chk("request without global", 32'h0, {31'h0, irq_request});
      wr(A_IC, 8'hA4);
      repeat (40) @(posedge aclk);
      chk("request held", 32'h1, {31'h0, irq_request});
      wr(A_IC, 8'hA0);
      chk("request cleared", 32'h0, {31'h0, irq_request});
      wr(A_CTL, 8'h01);
      rd(A_CNT);
      c0 = rd_data[7:0];
      repeat (64) @(posedge aclk);
      rd(A_CNT);
      chk("count in sleep", {24'h0, c0}, rd_data);
      wr(A_CTL, 8'h00);
      ext_chk(8'h28, 5, 32'h05);
      ext_chk(8'h38, 3, 32'h03);
      ext_chk(8'h20, 6, 32'h03);
      rd(A_CTL);
      chk("control readback", 32'h00, rd_data);
      wr(A_CTL, 8'h02);
      wr(A_CNT, 8'h00);
      wr(A_OPT, 8'h0F);
      wr(A_CTL, 8'h02);
      w0 = wdt_ticks;
      repeat (240) @(posedge aclk);
      chk("watchdog early tick", 32'h0, wdt_ticks - w0);
      repeat (40) @(posedge aclk);
      chk("watchdog 1:128 tick", 32'h1, wdt_ticks - w0);
      wr(A_CTL, 8'h02);
      wr(A_OPT, 8'h20);
      wr(A_IC, 8'h00);
      pin_chk(1'b1, 32'h00);
      pin_chk(1'b0, 32'h02);
      wr(A_IC, 8'h00);
      wr(A_OPT, 8'h60);
      pin_chk(1'b1, 32'h02);
      stop_test();
   end
endmodule
